//--- common/beam_rf_pid_defines.vh
`ifndef BEAM_RF_PID_DEFINES_VH
`define BEAM_RF_PID_DEFINES_VH

// System size
`define NUM_BOARDS       10
`define CH_PER_BOARD     32
`define NUM_CH           320
`define NUM_TYPES        3

// Channel layout: two focal planes, then three target planes
`define FP_PLANE_FIBERS  110
`define FP_PLANE_A_LO    0
`define FP_PLANE_B_LO    110
`define FP_USED_CH       220
`define FP_BOARDS        7
`define TG_PLANE_CH      32
`define TG_FIRST_CH      224
`define NUM_PLANES       5

// Type slot positions in flag triples
`define TYPE_ELEC        0
`define TYPE_MUON        1
`define TYPE_PION        2

// Time figures in picoseconds
`define CLK_PERIOD_PS    4000
`define BIN_WIDTH_PS     1250
`define FINE_STEP_PS     250
`define NUM_BINS         16

// Derived counts in fine-time steps
`define FINE_PER_CLK     (`CLK_PERIOD_PS / `FINE_STEP_PS)
`define FINE_PER_BIN     (`BIN_WIDTH_PS / `FINE_STEP_PS)
`define RF_PERIOD_FINE   (`NUM_BINS * `FINE_PER_BIN)
`define RF_CNT_MAX       3'h4

// Divide-by-five as multiply and shift, exact for 0..79
`define DIV5_MULT        8'hCD
`define DIV5_SHIFT       10

// Acceptance window: centroid bin plus this many on each side
`define WINDOW_HALF      2

// Reset values
`define RF_CNT_RST       3'h0
`define FINE_RST         4'h0
`define FLAGS_RST        3'h0

`endif

//--- rtl/rf_bin_channel.v
`timescale 1ns/1ns
`default_nettype none
`include "beam_rf_pid_defines.vh"

module rf_bin_channel (
  input  wire        mclk_i,
  input  wire        rst_n_i,
  input  wire        hit_i,
  input  wire [3:0]  fine_i,
  input  wire [2:0]  rf_cnt_i,
  input  wire [3:0]  rf_fine_i,
  input  wire [47:0] map_i,
  output reg  [2:0]  flags_o
);

  reg  [8:0]  sum_nxt;
  reg  [6:0]  t_nxt;
  reg  [8:0]  fold_nxt;
  wire [14:0] prod;
  wire [3:0]  bin;
  wire [2:0]  flags_nxt;

  // Hit time since last RF edge, in fine steps, folded into one period
  always @* begin
    sum_nxt = {2'b00, rf_cnt_i, 4'b0000} + {5'b0_0000, fine_i}
            + 9'd80 - {5'b0_0000, rf_fine_i};
    if (sum_nxt >= 9'h0A0)
      fold_nxt = sum_nxt - 9'h0A0;
    else if (sum_nxt >= 9'h050)
      fold_nxt = sum_nxt - 9'h050;
    else
      fold_nxt = sum_nxt;
    // Folded value is below one period, so seven bits always hold it
    t_nxt = fold_nxt[6:0];
  end

  // Divide by five fine steps per bin without a divider
  assign prod = {8'h00, t_nxt} * {7'h00, `DIV5_MULT};
  assign bin  = prod[13:10];

  // Every mapped type fires together on one hit
  assign flags_nxt = {map_i[32 + bin], map_i[16 + bin], map_i[bin]} & {3{hit_i}};

  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flags_o <= `FLAGS_RST;
    end else begin
      flags_o <= flags_nxt;
    end
  end

endmodule

`default_nettype wire

//--- rtl/beam_rf_time_particle_classifier.v
`timescale 1ns/1ns
`default_nettype none
`include "beam_rf_pid_defines.vh"

module beam_rf_time_particle_classifier (
  input  wire          mclk_i,
  input  wire          rst_n_i,
  input  wire [319:0]  hit_i,
  input  wire [1279:0] fine_i,
  input  wire          rf_i,
  input  wire [3:0]    rf_fine_i,
  input  wire          custom_map_i,
  input  wire [47:0]   fp_map_i,
  input  wire [47:0]   tg_map_i,
  input  wire [11:0]   fp_center_i,
  input  wire [11:0]   tg_center_i,
  input  wire          elec_majority_i,
  input  wire          muon_majority_i,
  output reg  [29:0]   board_o,
  output reg  [2:0]    scaler_coinc_o,
  output reg  [2:0]    trig_coinc_o,
  output reg  [14:0]   plane_o,
  output reg  [2:0]    accidental_o
);

  ////////////////////////////////////////////////////////////////////////
  // RF phase tracking

  reg [2:0] rf_cnt_r;
  reg [3:0] rf_fine_r;

  // Restart on each RF edge; saturate so a lost RF still folds sanely
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rf_cnt_r  <= `RF_CNT_RST;
      rf_fine_r <= `FINE_RST;
    end else if (rf_i) begin
      rf_cnt_r  <= `RF_CNT_RST;
      rf_fine_r <= rf_fine_i;
    end else if (rf_cnt_r < `RF_CNT_MAX) begin
      rf_cnt_r  <= rf_cnt_r + 3'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Bin maps: explicit map or five-bin window around a centroid

  wire [47:0] fp_win;
  wire [47:0] tg_win;
  wire [47:0] fp_map;
  wire [47:0] tg_map;

  // Full-width constants; only their low nibble enters the 4-bit wrap arithmetic
  localparam [31:0] win_half = `WINDOW_HALF;
  localparam [31:0] win_span = 2 * `WINDOW_HALF;

  // Window wraps around the period since RF phase is arbitrary
  genvar gt, gb;
  generate
    for (gt = 0; gt < `NUM_TYPES; gt = gt + 1) begin : g_type
      for (gb = 0; gb < `NUM_BINS; gb = gb + 1) begin : g_bin
        localparam [31:0] bin_idx = gb;
        wire [3:0] fp_d = bin_idx[3:0] - fp_center_i[gt*4 +: 4] + win_half[3:0];
        wire [3:0] tg_d = bin_idx[3:0] - tg_center_i[gt*4 +: 4] + win_half[3:0];
        assign fp_win[gt*16 + gb] = (fp_d <= win_span[3:0]);
        assign tg_win[gt*16 + gb] = (tg_d <= win_span[3:0]);
      end
    end
  endgenerate

  assign fp_map = custom_map_i ? fp_map_i : fp_win;
  assign tg_map = custom_map_i ? tg_map_i : tg_win;

  ////////////////////////////////////////////////////////////////////////
  // Channels

  wire [959:0] ch_flags;

  // Channels past the second focal plane on board six carry no fiber
  genvar gc;
  generate
    for (gc = 0; gc < `NUM_CH; gc = gc + 1) begin : g_ch
      wire used = (gc < `FP_USED_CH) || (gc >= `TG_FIRST_CH);
      rf_bin_channel u_ch (
        .mclk_i    (mclk_i),
        .rst_n_i   (rst_n_i),
        .hit_i     (hit_i[gc] & used),
        .fine_i    (fine_i[gc*4 +: 4]),
        .rf_cnt_i  (rf_cnt_r),
        .rf_fine_i (rf_fine_r),
        .map_i     ((gc < `TG_FIRST_CH) ? fp_map : tg_map),
        .flags_o   (ch_flags[gc*3 +: 3])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Board OR and plane OR, one stage

  reg  [29:0] board_nxt;
  reg  [14:0] plane_nxt;
  reg  [14:0] plane_r;
  reg  [29:0] board_r;
  integer     c;

  // Board OR also merges same-type hits, so such accidentals vanish here
  always @* begin
    board_nxt = 30'h0000_0000;
    plane_nxt = 15'h0000;
    for (c = 0; c < `NUM_CH; c = c + 1) begin
      board_nxt[(c / `CH_PER_BOARD)*3 +: 3] = board_nxt[(c / `CH_PER_BOARD)*3 +: 3]
                                            | ch_flags[c*3 +: 3];
      if (c < `FP_PLANE_B_LO)
        plane_nxt[2:0] = plane_nxt[2:0] | ch_flags[c*3 +: 3];
      else if (c < `FP_USED_CH)
        plane_nxt[5:3] = plane_nxt[5:3] | ch_flags[c*3 +: 3];
      else if (c >= `TG_FIRST_CH)
        plane_nxt[((c - `TG_FIRST_CH) / `TG_PLANE_CH + 2)*3 +: 3] =
          plane_nxt[((c - `TG_FIRST_CH) / `TG_PLANE_CH + 2)*3 +: 3] | ch_flags[c*3 +: 3];
    end
  end

  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      board_r <= 30'h0000_0000;
      plane_r <= 15'h0000;
    end else begin
      board_r <= board_nxt;
      plane_r <= plane_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Detector OR

  reg  [2:0] fp_det_nxt;
  reg  [2:0] tg_or_nxt;
  reg  [2:0] fp_det_r;
  reg  [2:0] tg_det_r;
  reg  [2:0] tg_maj;
  wire [2:0] tg_det_nxt;
  integer    b;

  // Boards 0..6 face the focal point, 7..9 the target
  always @* begin
    fp_det_nxt = `FLAGS_RST;
    tg_or_nxt  = `FLAGS_RST;
    for (b = 0; b < `NUM_BOARDS; b = b + 1) begin
      if (b < `FP_BOARDS)
        fp_det_nxt = fp_det_nxt | board_r[b*3 +: 3];
      else
        tg_or_nxt  = tg_or_nxt | board_r[b*3 +: 3];
    end
  end

  // Two-of-three across the target planes, per type
  always @* begin
    tg_maj = (plane_r[8:6] & plane_r[11:9]) | (plane_r[8:6] & plane_r[14:12])
           | (plane_r[11:9] & plane_r[14:12]);
  end

  // Pions always use the plain OR; the option covers electrons and muons only
  assign tg_det_nxt[`TYPE_ELEC] = elec_majority_i ? tg_maj[`TYPE_ELEC]
                                                  : tg_or_nxt[`TYPE_ELEC];
  assign tg_det_nxt[`TYPE_MUON] = muon_majority_i ? tg_maj[`TYPE_MUON]
                                                  : tg_or_nxt[`TYPE_MUON];
  assign tg_det_nxt[`TYPE_PION] = tg_or_nxt[`TYPE_PION];

  reg [29:0] board_d_r;
  reg [14:0] plane_d_r;

  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fp_det_r  <= `FLAGS_RST;
      tg_det_r  <= `FLAGS_RST;
      board_d_r <= 30'h0000_0000;
      plane_d_r <= 15'h0000;
    end else begin
      fp_det_r  <= fp_det_nxt;
      tg_det_r  <= tg_det_nxt;
      board_d_r <= board_r;
      plane_d_r <= plane_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Coincidence and outputs

  wire [2:0] coinc;

  // Same-cycle AND: flight-time skew must be absorbed by the bin maps
  assign coinc = fp_det_r & tg_det_r;

  // All side outputs are delayed to line up with the coincidence
  always @(posedge mclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      board_o        <= 30'h0000_0000;
      plane_o        <= 15'h0000;
      scaler_coinc_o <= `FLAGS_RST;
      trig_coinc_o   <= `FLAGS_RST;
      accidental_o   <= `FLAGS_RST;
    end else begin
      board_o        <= board_d_r;
      plane_o        <= plane_d_r;
      scaler_coinc_o <= coinc;
      trig_coinc_o   <= coinc;
      accidental_o   <= {coinc[`TYPE_MUON] & coinc[`TYPE_PION],
                         coinc[`TYPE_ELEC] & coinc[`TYPE_PION],
                         coinc[`TYPE_ELEC] & coinc[`TYPE_MUON]};
    end
  end

endmodule

`default_nettype wire

//--- verif/pid_monitor.sv
`timescale 1ns/1ns
`default_nettype none
module pid_monitor (
  input wire logic          mclk_i,
  input wire logic          rst_n_i,
  input wire logic [319:0]  hit_i,
  input wire logic          elec_majority_i,
  input wire logic          muon_majority_i,
  input wire logic [29:0]   board_o,
  input wire logic [2:0]    scaler_coinc_o,
  input wire logic [2:0]    trig_coinc_o,
  input wire logic [14:0]   plane_o,
  input wire logic [2:0]    accidental_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);
  // Detector views rebuilt from the per-plane feeds; fpb rebuilds the focal view from the board feeds
  wire [2:0] fp = plane_o[2:0] | plane_o[5:3];
  wire [2:0] ta = plane_o[8:6], tb = plane_o[11:9], tc = plane_o[14:12];
  wire [2:0] tg = ta | tb | tc;
  wire [2:0] mj = (ta & tb) | (ta & tc) | (tb & tc);
  wire [2:0] fpb = board_o[2:0] | board_o[5:3] | board_o[8:6] | board_o[11:9]
                 | board_o[14:12] | board_o[17:15] | board_o[20:18];
  wire [2:0] ex = fp & {tg[2], muon_majority_i ? mj[1] : tg[1], elec_majority_i ? mj[0] : tg[0]};
  property p_mirror; scaler_coinc_o == trig_coinc_o; endproperty
  a_mirror: assert property (p_mirror) else $error("scaler and trigger differ");
  // Only judged once the mode selects have settled through the pipe
  property p_coinc;
    ($stable(elec_majority_i) && $stable(muon_majority_i))[*5] |-> scaler_coinc_o == ex;
  endproperty
  a_coinc: assert property (p_coinc) else $error("coincidence wrong");
  property p_pion; scaler_coinc_o[2] == (fp[2] & tg[2]); endproperty
  a_pion: assert property (p_pion) else $error("pion target not ORed");
  property p_accid;
    accidental_o == {scaler_coinc_o[1] & scaler_coinc_o[2],
                     scaler_coinc_o[0] & scaler_coinc_o[2], scaler_coinc_o[0] & scaler_coinc_o[1]};
  endproperty
  a_accid: assert property (p_accid) else $error("accidental pair wrong");
  property p_fp_boards; fpb == fp; endproperty
  a_fp_boards: assert property (p_fp_boards) else $error("focal boards vs planes");
  property p_tg_boards; board_o[29:21] == plane_o[14:6]; endproperty
  a_tg_boards: assert property (p_tg_boards) else $error("target boards vs planes");
  property p_rst; $rose(rst_n_i) |-> {board_o, scaler_coinc_o, plane_o, accidental_o} == 0; endproperty
  a_rst: assert property (p_rst) else $error("outputs not idle after reset");
  property p_cause; |board_o |-> $past(|hit_i, 4); endproperty
  a_cause: assert property (p_cause) else $error("board flag without hit");
  c_elec: cover property (scaler_coinc_o[0]);
  c_acc: cover property (|accidental_o);
  c_maj: cover property (elec_majority_i && scaler_coinc_o[0]);
endmodule
bind beam_rf_time_particle_classifier pid_monitor mon_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
  .hit_i(hit_i), .elec_majority_i(elec_majority_i), .muon_majority_i(muon_majority_i),
  .board_o(board_o), .scaler_coinc_o(scaler_coinc_o), .trig_coinc_o(trig_coinc_o),
  .plane_o(plane_o), .accidental_o(accidental_o));
`default_nettype wire

//--- verif/fiber_rf_source.sv
`timescale 1ns/1ns
`default_nettype none
module fiber_rf_source (
  input wire logic     mclk_i,
  output var logic [319:0]  hit_o,
  output var logic [1279:0] fine_o,
  output var logic          rf_o,
  output var logic [3:0]    rf_fine_o
);
  logic [319:0]  hit_n = 0;
  logic [1279:0] fine_n = 0;
  logic          rf_n = 0;
  logic [3:0]    rff_n = 0;
  initial {hit_o, fine_o, rf_o, rf_fine_o} = 0;
  // Launch staged pulses; idle time lines flip so stale values never look valid
  always @(posedge mclk_i) begin
    #1;
    hit_o = hit_n;
    rf_o = rf_n;
    fine_o = |hit_n ? fine_n : ~fine_o;
    rf_fine_o = rf_n ? rff_n : ~rf_fine_o;
    hit_n = 0;
    rf_n = 0;
  end
endmodule
`default_nettype wire

//--- verif/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic mclk_i = 0, rst_n_i = 0, custom_map_i = 0, elec_majority_i = 0, muon_majority_i = 0;
  logic [47:0] fp_map_i = 0, tg_map_i = 0;
  logic [11:0] fp_center_i = 0, tg_center_i = 0;
  wire [319:0] hit_i;
  wire [1279:0] fine_i;
  wire rf_i;
  wire [3:0] rf_fine_i;
  wire [29:0] board_o;
  wire [2:0] scaler_coinc_o, trig_coinc_o, accidental_o;
  wire [14:0] plane_o;
  logic [319:0] h;
  logic [1279:0] fn;
  logic [3:0] rff;
  logic [50:0] q[$];
  logic [50:0] cur_exp = 0;
  logic [50:0] note;
  int cnt, cyc, j, n_fail, samples_checked;
  always #2 mclk_i = ~mclk_i;
  fiber_rf_source src_u (.mclk_i(mclk_i), .hit_o(hit_i), .fine_o(fine_i), .rf_o(rf_i),
    .rf_fine_o(rf_fine_i));
  beam_rf_time_particle_classifier dut_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .hit_i(hit_i),
    .fine_i(fine_i), .rf_i(rf_i), .rf_fine_i(rf_fine_i), .custom_map_i(custom_map_i),
    .fp_map_i(fp_map_i), .tg_map_i(tg_map_i), .fp_center_i(fp_center_i),
    .tg_center_i(tg_center_i), .elec_majority_i(elec_majority_i),
    .muon_majority_i(muon_majority_i), .board_o(board_o), .scaler_coinc_o(scaler_coinc_o),
    .trig_coinc_o(trig_coinc_o), .plane_o(plane_o), .accidental_o(accidental_o));
  ////////////////////////////////////////////////////////////////////////////////
  // Reference: bin each hit, map it, then fold boards, planes and detectors
  function automatic logic [50:0] calc(input logic [319:0] hh);
    logic [2:0] f, fp, a, b, c, t, co;
    logic [14:0] pl;
    logic [29:0] bd;
    logic [47:0] m;
    logic [11:0] ce;
    int n, k, bn, p;
    pl = 0;
    bd = 0;
    for (n = 0; n < 320; n++) if (hh[n] && (n < 220 || n > 223)) begin
      bn = ((16 * cnt + fn[4*n+:4] + 80 - rff) % 80) / 5;
      m = n < 224 ? fp_map_i : tg_map_i;
      ce = n < 224 ? fp_center_i : tg_center_i;
      for (k = 0; k < 3; k++) f[k] = custom_map_i ? m[16*k+bn] : (bn - ce[4*k+:4] + 18) % 16 < 5;
      p = n < 110 ? 0 : n < 220 ? 1 : (n - 160) / 32;
      pl[3*p+:3] |= f;
      bd[3*(n/32)+:3] |= f;
    end
    fp = pl[2:0] | pl[5:3];
    a = pl[8:6];
    b = pl[11:9];
    c = pl[14:12];
    t = a | b | c;
    if (elec_majority_i) t[0] = a[0] & b[0] | a[0] & c[0] | b[0] & c[0];
    if (muon_majority_i) t[1] = a[1] & b[1] | a[1] & c[1] | b[1] & c[1];
    co = fp & t;
    return {bd, co, pl, co[1] & co[2], co[0] & co[2], co[0] & co[1]};
  endfunction
  task tally_and_finish;
    if (n_fail == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task cmp(input logic [50:0] e, input logic [50:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // Trigger copy of the coincidence, checked on its own
  task cmp_trig(input logic [2:0] e, input logic [2:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %0t trigger got %h exp %h", $time, g, e);
    end
  endtask
  // Stage one cycle of stimulus in the source and its expected outcome
  task step(input logic r, input logic [319:0] hh);
    src_u.rf_n = r;
    src_u.rff_n = rff;
    src_u.hit_n = hh;
    src_u.fine_n = fn;
    if (|hh) cur_exp = calc(hh);
    @(posedge mclk_i);
    #3;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // Expectation joins the queue as the staged cycle reaches the pins, well before the negedge
  always @(posedge mclk_i) begin
    #1;
    q.push_back(cur_exp);
    cur_exp = 0;
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      tally_and_finish;
    end
  end
  // Four register stages after the sampling edge: the answer is four notes behind
  always @(negedge mclk_i) begin
    while (q.size() > 4) begin
      note = q.pop_front();
      cmp(note, {board_o, scaler_coinc_o, plane_o, accidental_o});
      cmp_trig(note[20:18], trig_coinc_o);
    end
  end
  initial begin
    cnt = $urandom(32'h20d2);
    fn = 0;
    repeat (5) @(posedge mclk_i);
    #3 rst_n_i = 1;
    @(posedge mclk_i);
    #3;
    for (int i = 0; i < 60; i++) begin
      custom_map_i = i[0];
      fp_map_i = 48'({$urandom(), $urandom()});
      tg_map_i = 48'({$urandom(), $urandom()});
      fp_center_i = 12'($urandom());
      tg_center_i = 12'($urandom());
      {elec_majority_i, muon_majority_i} = 2'($urandom());
      rff = 4'($urandom());
      cnt = $urandom_range(0, 5);
      step(1, 0);
      repeat (cnt) step(0, 0);
      if (cnt > 4) cnt = 4;
      h = 0;
      for (int k = 0; k < 7; k++) begin
        j = k < 3 ? $urandom_range(0, 219) : $urandom_range(224, 319);
        h[j] = 1;
        fn[4*j+:4] = 4'($urandom());
      end
      h[220+i%4] = 1;
      step(0, h);
      repeat (6) step(0, 0);
    end
    repeat (8) @(posedge mclk_i);
    tally_and_finish;
  end
endmodule
`default_nettype wire
